// ---- design/buck_ctrl_pkg.sv ----
// Package with timing constants and state types for the buck PWM control core.
package buck_ctrl_pkg;

  // Clock rate in kHz and documented times.
  localparam int unsigned CLK_FREQ_KHZ      = 100000;
  localparam int unsigned MIN_ON_NS         = 180;
  localparam int unsigned OC_FILTER_NS      = 100;
  // Counts of cycles: least times round up.
  localparam int unsigned MIN_ON_CYCLES     = (MIN_ON_NS * (CLK_FREQ_KHZ / 1000) + 999) / 1000;
  localparam int unsigned OC_FILTER_CYCLES  = (OC_FILTER_NS * (CLK_FREQ_KHZ / 1000) + 999) / 1000;

  // Slow start and hiccup lengths in switching cycles.
  localparam int unsigned SS_SW_CYCLES      = 1150;
  localparam int unsigned HICCUP_SW_CYCLES  = 2250;

  // Width of the reference code handed to the analog side.
  localparam int unsigned REF_W             = 11;
  localparam logic [10:0] REF_RESET         = 11'h000;

  // Synchroniser depth for pin inputs.
  localparam int unsigned SYNC_STAGES       = 3;

  typedef enum logic [1:0] {
    PH_OFF,
    PH_WAIT_LOW_OFF,
    PH_HIGH_ON,
    PH_WAIT_HIGH_OFF
  } drive_state_t;

  typedef enum logic [1:0] {
    RUN_IDLE,
    RUN_SOFTSTART,
    RUN_REGULATE,
    RUN_HICCUP
  } run_state_t;

endpackage

// ---- design/pin_sync.sv ----
// Three-stage synchroniser; output changes once stages one and two agree.
module pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Asynchronous input and clean level
  input  wire logic async_in,
  output logic      sync_out
);

  logic [2:0] stage_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage_r <= {3{RESET_VAL}};
    end else begin
      stage_r <= {stage_r[1:0], async_in};
    end
  end

  // Stage zero is read only by stage one.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_out <= RESET_VAL;
    end else if (stage_r[1] == stage_r[2]) begin
      sync_out <= stage_r[2];
    end
  end

endmodule

// ---- design/osc_divider.sv ----
// Divides the oscillator pulse train into switching periods and flags each one on sw_tick.
module osc_divider (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Oscillator pulse, clean level
  input  wire logic osc_level,
  // Outputs
  output logic      osc_rise,
  output logic      osc_fall,
  output logic      sw_tick
);

  logic osc_d_r;
  logic half_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_d_r <= 1'b0;
    end else begin
      osc_d_r <= osc_level;
    end
  end

  assign osc_rise = osc_level & ~osc_d_r;
  assign osc_fall = ~osc_level & osc_d_r;

  // Two oscillator periods make one switching period.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      half_r <= 1'b0;
    end else if (osc_rise) begin
      half_r <= ~half_r;
    end
  end

  assign sw_tick = osc_rise & half_r;

endmodule

// ---- design/buck_pwm_control_protection.sv ----
// Digital control core of a synchronous buck switcher: PWM latch, dead time, protection.
// Operation
// - Oscillator pulse sets the PWM latch; ramp comparator clears it.
// - After latch clears, low side and pull-down stay on through oscillator pulse.
// - When the pulse ends, low side goes off, then high side turns on.
// - Comparator trip turns high side off and low side on until next pulse.
// - No trip: high side stays on until oscillator pulse forces it off.
// - Comparator stuck asserted: latch held clear, high side never on.
// - Each high-side interval lasts at least the minimum on time unless over-temperature or overcurrent cuts it short.
// - Slow start steps the reference from zero up to its final value.
// - High side waits until low-side gate sense shows gate below threshold.
// - Low side waits until high-side gate sense shows gate below threshold.
// - Over-temperature turns off both drives and halts the controller.
// - Restart after thermal hysteresis with a full slow-start ramp.
// - Overcurrent past filter time: pull run pin low, high side off, ramp reset.
// - Run pin held low for a fixed number of switching cycles.
// - After hiccup, release run pin and restart slow start.
// - Slow start reaches final value over a fixed count of switching cycles.
// - Run pin seen low stops switching and resets slow start.
// - Oscillator runs at twice the switching rate.
module buck_pwm_control_protection #(
  parameter int unsigned CLK_FREQ_KHZ     = buck_ctrl_pkg::CLK_FREQ_KHZ,
  parameter int unsigned SS_SW_CYCLES     = buck_ctrl_pkg::SS_SW_CYCLES,
  parameter int unsigned HICCUP_SW_CYCLES = buck_ctrl_pkg::HICCUP_SW_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Oscillator pulse and ramp comparator
  input  wire logic        osc_pulse,
  input  wire logic        ramp_cmp,
  // Gate-level sense, high while that gate is above the interlock threshold
  input  wire logic        high_gate_sense,
  input  wire logic        low_gate_sense,
  // Protection comparators
  input  wire logic        over_temp,
  input  wire logic        over_current,
  // Run request pin, open drain
  input  wire logic        run_request_pin_in,
  output logic             run_request_pin_out,
  output logic             run_request_pin_oe,
  // Gate drives
  output logic             high_side_drive,
  output logic             low_side_gate_drive,
  output logic             pulldown_drive,
  // Reference code and status
  output logic [10:0]      ref_code,
  output logic             soft_start_active,
  output logic             fault_active
);

  localparam int unsigned MIN_ON_CYC =
    (buck_ctrl_pkg::MIN_ON_NS * (CLK_FREQ_KHZ / 1000) + 999) / 1000;
  localparam int unsigned OC_CYC =
    (buck_ctrl_pkg::OC_FILTER_NS * (CLK_FREQ_KHZ / 1000) + 999) / 1000;
  localparam int unsigned MIN_ON_N = (MIN_ON_CYC < 1) ? 1 : MIN_ON_CYC;
  localparam int unsigned OC_N     = (OC_CYC < 1) ? 1 : OC_CYC;

  // Synchronise analog inputs
  // Gate senses and over-temperature reset high, so no drive starts before the inputs settle.
  logic osc_s;
  logic cmp_s;
  logic hgs_s;
  logic lgs_s;
  logic ot_s;
  logic oc_s;
  logic run_s;

  pin_sync #(.RESET_VAL(1'b0)) u_sync_osc (.clk(clk), .rst_n(rst_n),
    .async_in(osc_pulse), .sync_out(osc_s));
  pin_sync #(.RESET_VAL(1'b0)) u_sync_cmp (.clk(clk), .rst_n(rst_n),
    .async_in(ramp_cmp), .sync_out(cmp_s));
  pin_sync #(.RESET_VAL(1'b1)) u_sync_hgs (.clk(clk), .rst_n(rst_n),
    .async_in(high_gate_sense), .sync_out(hgs_s));
  pin_sync #(.RESET_VAL(1'b1)) u_sync_lgs (.clk(clk), .rst_n(rst_n),
    .async_in(low_gate_sense), .sync_out(lgs_s));
  pin_sync #(.RESET_VAL(1'b1)) u_sync_ot (.clk(clk), .rst_n(rst_n),
    .async_in(over_temp), .sync_out(ot_s));
  pin_sync #(.RESET_VAL(1'b0)) u_sync_oc (.clk(clk), .rst_n(rst_n),
    .async_in(over_current), .sync_out(oc_s));
  pin_sync #(.RESET_VAL(1'b0)) u_sync_run (.clk(clk), .rst_n(rst_n),
    .async_in(run_request_pin_in), .sync_out(run_s));

  logic osc_rise;
  logic osc_fall;
  logic sw_tick;

  osc_divider u_div (
    .clk       (clk),
    .rst_n     (rst_n),
    .osc_level (osc_s),
    .osc_rise  (osc_rise),
    .osc_fall  (osc_fall),
    .sw_tick   (sw_tick)
  );

  buck_ctrl_pkg::run_state_t   run_r;
  buck_ctrl_pkg::drive_state_t drv_r;
  logic        latch_r;
  logic [15:0] min_on_cnt_r;
  logic [7:0]  oc_cnt_r;
  logic [15:0] sw_cnt_r;
  logic        oc_trip;
  logic        halt;

  // Thermal halt
  // The halt is level driven; the temperature comparator supplies the hysteresis.
  assign halt = ot_s;

  assign oc_trip = oc_s && (oc_cnt_r >= 8'(OC_N));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oc_cnt_r <= 8'h00;
    end else if (!oc_s || high_side_drive == 1'b0) begin
      oc_cnt_r <= 8'h00;
    end else if (oc_cnt_r != 8'hff) begin
      oc_cnt_r <= oc_cnt_r + 8'h01;
    end
  end

  // Run sequencing: soft start, regulation, hiccup.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_r    <= buck_ctrl_pkg::RUN_IDLE;
      sw_cnt_r <= 16'h0000;
    end else if (halt) begin
      run_r    <= buck_ctrl_pkg::RUN_IDLE;
      sw_cnt_r <= 16'h0000;
    end else begin
      case (run_r)
        buck_ctrl_pkg::RUN_IDLE: begin
          sw_cnt_r <= 16'h0000;
          if (run_s) begin
            run_r <= buck_ctrl_pkg::RUN_SOFTSTART;
          end
        end
        buck_ctrl_pkg::RUN_SOFTSTART, buck_ctrl_pkg::RUN_REGULATE: begin
          if (oc_trip) begin
            run_r    <= buck_ctrl_pkg::RUN_HICCUP;
            sw_cnt_r <= 16'h0000;
          end else if (!run_s) begin
            run_r    <= buck_ctrl_pkg::RUN_IDLE;
            sw_cnt_r <= 16'h0000;
          end else if (run_r == buck_ctrl_pkg::RUN_SOFTSTART && sw_tick) begin
            if (sw_cnt_r >= 16'(SS_SW_CYCLES - 1)) begin
              run_r <= buck_ctrl_pkg::RUN_REGULATE;
            end
            sw_cnt_r <= sw_cnt_r + 16'h0001;
          end
        end
        buck_ctrl_pkg::RUN_HICCUP: begin
          if (sw_tick) begin
            if (sw_cnt_r >= 16'(HICCUP_SW_CYCLES - 1)) begin
              run_r    <= buck_ctrl_pkg::RUN_IDLE;
              sw_cnt_r <= 16'h0000;
            end else begin
              sw_cnt_r <= sw_cnt_r + 16'h0001;
            end
          end
        end
        default: run_r <= buck_ctrl_pkg::RUN_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_request_pin_out <= 1'b0;
      run_request_pin_oe  <= 1'b0;
    end else begin
      run_request_pin_out <= 1'b0;
      run_request_pin_oe  <= (run_r == buck_ctrl_pkg::RUN_HICCUP) && !halt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_code <= buck_ctrl_pkg::REF_RESET;
    end else if (run_r == buck_ctrl_pkg::RUN_SOFTSTART) begin
      ref_code <= 11'(sw_cnt_r);
    end else if (run_r == buck_ctrl_pkg::RUN_REGULATE) begin
      ref_code <= 11'(SS_SW_CYCLES);
    end else begin
      ref_code <= buck_ctrl_pkg::REF_RESET;
    end
  end

  logic running;
  assign running = !halt && run_s &&
    (run_r == buck_ctrl_pkg::RUN_SOFTSTART || run_r == buck_ctrl_pkg::RUN_REGULATE);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_r <= 1'b0;
    end else if (!running || oc_trip) begin
      latch_r <= 1'b0;
    end else if (osc_rise && !cmp_s) begin
      latch_r <= 1'b1;
    end else if (osc_rise) begin
      latch_r <= 1'b0;
    end else if (cmp_s && latch_r && drv_r == buck_ctrl_pkg::PH_HIGH_ON
                 && min_on_cnt_r >= 16'(MIN_ON_N)) begin
      latch_r <= 1'b0;
    end
  end

  logic want_high;
  assign want_high = latch_r && !osc_s;

  // Gate sequencing with adaptive dead time.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drv_r        <= buck_ctrl_pkg::PH_OFF;
      min_on_cnt_r <= 16'h0000;
    end else begin
      case (drv_r)
        buck_ctrl_pkg::PH_OFF: begin
          min_on_cnt_r <= 16'h0000;
          if (want_high && !oc_trip) begin
            drv_r <= buck_ctrl_pkg::PH_WAIT_LOW_OFF;
          end
        end
        buck_ctrl_pkg::PH_WAIT_LOW_OFF: begin
          if (!want_high || oc_trip) begin
            drv_r <= buck_ctrl_pkg::PH_OFF;
          end else if (!lgs_s) begin
            drv_r <= buck_ctrl_pkg::PH_HIGH_ON;
          end
        end
        buck_ctrl_pkg::PH_HIGH_ON: begin
          if (min_on_cnt_r != 16'hffff) begin
            min_on_cnt_r <= min_on_cnt_r + 16'h0001;
          end
          if (halt || oc_trip || (osc_rise && min_on_cnt_r >= 16'(MIN_ON_N)) ||
              (!latch_r && min_on_cnt_r >= 16'(MIN_ON_N))) begin
            drv_r <= buck_ctrl_pkg::PH_WAIT_HIGH_OFF;
          end
        end
        buck_ctrl_pkg::PH_WAIT_HIGH_OFF: begin
          min_on_cnt_r <= 16'h0000;
          if (!hgs_s) begin
            drv_r <= buck_ctrl_pkg::PH_OFF;
          end
        end
        default: drv_r <= buck_ctrl_pkg::PH_OFF;
      endcase
    end
  end

  // Drive outputs come straight from flops; low side is on only while running in PH_OFF, with the high gate below threshold and no high request.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      high_side_drive     <= 1'b0;
      low_side_gate_drive <= 1'b0;
      pulldown_drive      <= 1'b0;
    end else begin
      // High side on in PH_HIGH_ON; low side and pull-down on in PH_OFF
      // The two normal exits of the on state both wait for the minimum count; halt and oc_trip cut the pulse short.
      high_side_drive     <= !halt && !oc_trip
                             && drv_r == buck_ctrl_pkg::PH_HIGH_ON;
      low_side_gate_drive <= !halt && running && drv_r == buck_ctrl_pkg::PH_OFF
                             && !hgs_s && !want_high;
      pulldown_drive      <= !halt && running && drv_r == buck_ctrl_pkg::PH_OFF
                             && !want_high;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      soft_start_active <= 1'b0;
      fault_active      <= 1'b0;
    end else begin
      soft_start_active <= run_r == buck_ctrl_pkg::RUN_SOFTSTART;
      fault_active      <= halt || run_r == buck_ctrl_pkg::RUN_HICCUP;
    end
  end

endmodule

// ---- test/buck_pwm_control_protection_properties.sv ----
// Port-level checker of the buck control core, bound to its top module.
module buck_pwm_control_protection_properties #(
  parameter int unsigned SS_SW_CYCLES     = 8,
  parameter int unsigned HICCUP_SW_CYCLES = 8
) (
  // Watched ports
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        osc_pulse,
  input wire logic        high_gate_sense,
  input wire logic        low_gate_sense,
  input wire logic        over_temp,
  input wire logic        over_current,
  input wire logic        run_request_pin_in,
  input wire logic        run_request_pin_out,
  input wire logic        run_request_pin_oe,
  input wire logic        high_side_drive,
  input wire logic        low_side_gate_drive,
  input wire logic [10:0] ref_code,
  input wire logic        soft_start_active,
  input wire logic        fault_active
);
  localparam int MIN_ON = buck_ctrl_pkg::MIN_ON_CYCLES;
  localparam int SS_R   = 2 * SS_SW_CYCLES;
  localparam int HC_R   = 2 * HICCUP_SW_CYCLES;
  logic [3:0]  lgs_r, hgs_r, calm_r;
  logic [7:0]  on_r, oc_r;
  logic [11:0] ss_r, hc_r;
  logic        osc_r;
  // Calm is nonzero while a fault or a stop may legally cut a pulse short.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {lgs_r, hgs_r, calm_r, on_r, oc_r, ss_r, hc_r, osc_r} <= '0;
    end else begin
      osc_r  <= osc_pulse;
      lgs_r  <= low_gate_sense ? 4'h0 : lgs_r + 4'(lgs_r != 4'hf);
      hgs_r  <= high_gate_sense ? 4'h0 : hgs_r + 4'(hgs_r != 4'hf);
      calm_r <= (over_temp || over_current || !run_request_pin_in) ? 4'hf
                : calm_r - 4'(calm_r != 4'h0);
      on_r   <= high_side_drive ? on_r + 8'h01 : 8'h00;
      oc_r   <= (over_current && high_side_drive) ? oc_r + 8'h01 : 8'h00;
      ss_r   <= soft_start_active ? ss_r + 12'(osc_pulse && !osc_r) : 12'h000;
      hc_r   <= run_request_pin_oe ? hc_r + 12'(osc_pulse && !osc_r) : 12'h000;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence ot_held_s;
    over_temp [*4];
  endsequence
  sequence drives_off_s;
    !high_side_drive && !low_side_gate_drive;
  endsequence
  sequence restart_s;
    ##[0:12] soft_start_active;
  endsequence
  no_overlap_a: assert property (!(high_side_drive && low_side_gate_drive))
    else $error("both gate drives on");
  high_wait_a: assert property ($rose(high_side_drive) |-> lgs_r >= 4'h2)
    else $error("high side on before low gate fell");
  low_wait_a: assert property ($rose(low_side_gate_drive) |-> hgs_r >= 4'h2)
    else $error("low side on before high gate fell");
  min_on_a: assert property (
      $fell(high_side_drive) && calm_r == 4'h0 |-> on_r >= 8'(MIN_ON))
    else $error("high side pulse too short");
  thermal_off_a: assert property (ot_held_s |-> ##[0:6] drives_off_s)
    else $error("drives on during over-temperature");
  oc_cut_a: assert property (oc_r < 8'h14)
    else $error("high side kept on under overcurrent");
  hiccup_safe_a: assert property (run_request_pin_oe |->
      !run_request_pin_out && !high_side_drive && ref_code == 11'h000)
    else $error("hiccup without stop");
  hiccup_len_a: assert property ($fell(run_request_pin_oe) |->
      hc_r >= 12'(HC_R - 2) && hc_r <= 12'(HC_R + 2))
    else $error("hiccup length wrong");
  restart_a: assert property ($fell(run_request_pin_oe) |-> restart_s)
    else $error("no slow start after hiccup");
  ref_step_a: assert property ($changed(ref_code) |->
      ref_code == $past(ref_code) + 11'h001 || ref_code == 11'h000)
    else $error("reference jumped");
  ss_len_a: assert property ($fell(soft_start_active) && calm_r == 4'h0 &&
      !fault_active && ref_code != 11'h000 |-> ss_r >= 12'(SS_R - 2) && ss_r <= 12'(SS_R + 2))
    else $error("slow start length wrong");
endmodule

bind buck_pwm_control_protection buck_pwm_control_protection_properties #(
  .SS_SW_CYCLES(SS_SW_CYCLES), .HICCUP_SW_CYCLES(HICCUP_SW_CYCLES)) i_props (.*);

// ---- test/buck_far_side.sv ----
// Far-side model: gate sense comparators and the open-drain run pin.
module buck_far_side (
  // Drives from the core
  input wire logic       clk,
  input wire logic       high_side_drive,
  input wire logic       low_side_gate_drive,
  input wire logic       run_request_pin_out,
  input wire logic       run_request_pin_oe,
  // Bench controls
  input wire logic       ext_pull,
  input wire logic [2:0] dly,
  // Sense back to the core
  output logic           high_gate_sense,
  output logic           low_gate_sense,
  output logic           run_request_pin_in
);
  // A gate crosses its threshold dly+1 cycles after the drive moves; large dly is a slow FET.
  logic [7:0] hs_r = 8'h00;
  logic [7:0] ls_r = 8'h00;
  always_ff @(posedge clk) begin
    hs_r <= {hs_r[6:0], high_side_drive};
    ls_r <= {ls_r[6:0], low_side_gate_drive};
  end
  assign high_gate_sense = hs_r[dly];
  assign low_gate_sense  = ls_r[dly];
  // Internal pull-up; the core or an outside open drain may pull the pin low.
  assign run_request_pin_in = !ext_pull && !(run_request_pin_oe && !run_request_pin_out);
endmodule

// ---- test/buck_pwm_control_protection_tb.sv ----
// Self-checking bench for the buck control core.
module buck_pwm_control_protection_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SS  = 8;
  localparam int HIC = 8;
  localparam int OP  = 60;
  localparam int OW  = 20;
  logic        clk, rst_n, osc_pulse, ramp_cmp, over_temp, over_current, ext_pull;
  logic        high_gate_sense, low_gate_sense, run_request_pin_in;
  logic        run_request_pin_out, run_request_pin_oe, high_side_drive;
  logic        low_side_gate_drive, pulldown_drive, soft_start_active, fault_active;
  logic [10:0] ref_code;
  logic [2:0]  dly;
  int          n_fail, comparisons, phase, duty, mode, n_hs, i;

  buck_pwm_control_protection #(.SS_SW_CYCLES(SS), .HICCUP_SW_CYCLES(HIC)) i_dut (.*);
  buck_far_side i_far (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Oscillator and ramp comparator; mode 1 keeps the error signal above the ramp peak,
  // mode 2 below the ramp valley.
  always @(negedge clk) begin
    phase = (phase == OP - 1) ? 0 : phase + 1;
    if (phase == 0) duty = $urandom % 30;
    osc_pulse = phase < OW;
    ramp_cmp  = (mode == 2) || ((mode == 0) && (phase >= OW + duty));
  end
  always @(posedge high_side_drive) n_hs++;

  function automatic int ss_clks();
    return 2 * SS * OP + 100;
  endfunction
  function automatic int hic_clks();
    return (HIC - 1) * 2 * OP - 20;
  endfunction

  task automatic step();
    @(negedge clk);
    #1;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) step();
  endtask
  task automatic chk(input bit ok, input string m);
    comparisons++;
    if (!ok) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic conclude();
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    conclude();
  end

  initial begin
    {rst_n, over_temp, over_current, ext_pull} = '0;
    dly = 3'h1;
    void'($urandom(32'h1270));
    wait_clk(10);
    rst_n = 1'b1;
    wait_clk(40);
    chk(soft_start_active === 1'b1 && ref_code < 11'h004, "slow start not begun");
    wait_clk(ss_clks());
    chk(soft_start_active === 1'b0 && ref_code === 11'(SS), "reference not final");
    for (i = 0; i < 4; i++) begin
      dly  = 3'(1 + $urandom % 6);
      mode = i % 3;
      wait_clk(OP);
      n_hs = 0;
      wait_clk(8 * OP);
      chk(mode == 2 ? (n_hs == 0 && low_side_gate_drive === 1'b1) : n_hs >= 3, "switching");
    end
    dly = 3'h1;
    for (i = 0; i < 4; i++) begin
      mode = i % 2;
      while (phase != OW - 1) step();
      chk(high_side_drive === 1'b0 && low_side_gate_drive === 1'b1
          && pulldown_drive === 1'b1, "low side off in pulse");
      step();
    end
    mode = 0;
    ext_pull = 1'b1;
    wait_clk(30);
    chk(high_side_drive === 1'b0 && ref_code === 11'h000
        && soft_start_active === 1'b0, "still running");
    ext_pull = 1'b0;
    wait_clk(30);
    chk(soft_start_active === 1'b1, "no slow start");
    over_current = 1'b1;
    for (i = 0; i < 400 && run_request_pin_oe !== 1'b1; i++) step();
    over_current = 1'b0;
    chk(run_request_pin_oe === 1'b1 && high_side_drive === 1'b0
        && ref_code === 11'h000, "no trip");
    wait_clk(hic_clks());
    chk(run_request_pin_oe === 1'b1, "hiccup short");
    wait_clk(4 * OP);
    chk(run_request_pin_oe === 1'b0 && soft_start_active === 1'b1, "no release");
    over_temp = 1'b1;
    wait_clk(20);
    chk(high_side_drive === 1'b0 && low_side_gate_drive === 1'b0
        && fault_active === 1'b1, "not halted");
    over_temp = 1'b0;
    wait_clk(20);
    chk(fault_active === 1'b0 && soft_start_active === 1'b1
        && ref_code < 11'h002, "no restart");
    conclude();
  end
endmodule
